// file: shared/sbw_pkg.sv
// Constants, types and helper functions shared by the window/time-out watchdog
package sbw_pkg;

    // Clock and time base
    localparam int CLK_HZ = 32'h0098_9680;
    localparam int MS_PER_S = 32'h0000_03E8;
    localparam int CYC_PER_MS_DEF = CLK_HZ / MS_PER_S;
    localparam int LONG_WIN_MS = 32'h0000_00C8;
    localparam int RST_HOLD_MS_DEF = 32'h0000_000A;
    localparam int CLOSED_PCT = 32'h0000_003C;
    localparam int PCT_FULL = 32'h0000_0064;
    localparam int TMR_W = 24;

    // Serial frame layout
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] FRAME_CNT_MAX = 5'h11;
    localparam logic [6:0] ADDR_SETUP = 7'h15;
    localparam logic [6:0] ADDR_WAKE = 7'h04;

    // Data byte fields of the setup register
    localparam int DAT_CHK = 7;
    localparam int DAT_CONFIRM = 6;
    localparam int DAT_TYPE = 5;
    localparam int DAT_BUSWAKE = 4;
    localparam int DAT_RSVD = 3;
    localparam int DAT_PER_HI = 2;
    localparam int DAT_PER_LO = 0;
    // Data byte field of the wake control register
    localparam int DAT_ARM = 0;

    // Failure counter saturation
    localparam logic [2:0] FAIL_CFG_TWO = 3'h2;
    localparam logic [1:0] FAIL_SAT_CFG2 = 2'h1;
    localparam logic [1:0] FAIL_SAT_OTHER = 2'h2;

    typedef enum logic [2:0] {
        CM_INIT = 3'h0,
        CM_NORMAL = 3'h1,
        CM_STOP = 3'h2,
        CM_SLEEP = 3'h3,
        CM_RESTART = 3'h4,
        CM_FAILSAFE = 3'h5
    } sbw_chip_mode_e;

    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_LONG = 4'h2,
        ST_RUN = 4'h4,
        ST_OFF = 4'h8
    } sbw_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic wr;
        logic [6:0] addr;
    } sbw_frame_s;

    typedef struct packed {
        logic win;
        logic [2:0] period;
        logic bus_wake;
    } sbw_cfg_s;

    localparam sbw_cfg_s CFG_RST = '{win: 1'h0, period: 3'h4, bus_wake: 1'h1};

    // Period setting to milliseconds; code 0 behaves as setting 1
    function automatic logic [31:0] period_ms(input logic [2:0] code);
        case (code)
            3'h2: period_ms = 32'h0000_0014;
            3'h3: period_ms = 32'h0000_0032;
            3'h4: period_ms = 32'h0000_0064;
            3'h5: period_ms = 32'h0000_00C8;
            3'h6: period_ms = 32'h0000_01F4;
            3'h7: period_ms = 32'h0000_03E8;
            default: period_ms = 32'h0000_000A;
        endcase
    endfunction

    function automatic logic [TMR_W-1:0] ms_to_cyc(input logic [31:0] ms,
                                                  input logic [31:0] cpm);
        logic [31:0] p;
        p = ms * cpm;
        ms_to_cyc = p[TMR_W-1:0];
    endfunction

endpackage

// file: core/sbw_link_rx.sv
// Serial receiver running on the host's serial clock
`timescale 1ns/1ps
module sbw_link_rx (
    // Link
    input wire logic i_serial_clk,
    input wire logic i_sys_rst,
    input wire logic i_serial_select_n,
    input wire logic i_serial_data_in,
    // Captured frame, stable while select is high
    output sbw_pkg::sbw_frame_s o_frame,
    output logic [4:0] o_bit_count
);
    import sbw_pkg::*;

    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic started_r;
    logic frame_clr;

    // Serial clock stops between frames, so the frame marker is cleared by select itself
    assign frame_clr = i_sys_rst | i_serial_select_n;

    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        if (!i_serial_select_n) begin
            shift_nxt = {shift_r[14:0], i_serial_data_in};
            if (!started_r) begin
                cnt_nxt = 5'h01;
            end else if (cnt_r != FRAME_CNT_MAX) begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
    end

    always_ff @(posedge i_serial_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_r <= 16'h0000;
            cnt_r <= 5'h00;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge i_serial_clk or posedge frame_clr) begin
        if (frame_clr) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    assign o_frame = shift_r;
    assign o_bit_count = cnt_r;

endmodule // sbw_link_rx

// file: core/sbw_watchdog.sv
// Window / time-out watchdog with checksum-guarded serial service and stop-mode disable
`timescale 1ns/1ps
module sbw_watchdog #(
    parameter int CYC_PER_MS = sbw_pkg::CYC_PER_MS_DEF,
    parameter int RST_HOLD_MS = sbw_pkg::RST_HOLD_MS_DEF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Serial link
    input wire logic i_serial_clk,
    input wire logic i_serial_select_n,
    input wire logic i_serial_data_in,
    // Chip state
    input sbw_pkg::sbw_chip_mode_e i_chip_mode,
    input wire logic i_dev_mode,
    input wire logic i_fail_safe_select,
    input wire logic [2:0] i_fail_config,
    // Bus wake events
    input wire logic i_can_wake,
    input wire logic i_lin_wake,
    // Reset and mode requests
    output logic o_reset_out_n,
    output logic o_enter_restart,
    output logic o_enter_failsafe,
    output logic o_enter_normal,
    // Host notification
    output logic o_wake_irq,
    output logic o_rxd_pull_low,
    output logic o_spi_fail,
    // Status
    output sbw_pkg::sbw_cfg_s o_cfg,
    output logic [1:0] o_watchdog_failure_count,
    output logic o_stop_disable_arm_bit,
    output logic o_stop_disable_confirm_bit,
    output logic o_wd_active
);
    import sbw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link receiver and crossing

    sbw_frame_s frame;
    logic [4:0] bit_count;

    sbw_link_rx u_link (
        .i_serial_clk(i_serial_clk),
        .i_sys_rst(i_sys_rst),
        .i_serial_select_n(i_serial_select_n),
        .i_serial_data_in(i_serial_data_in),
        .o_frame(frame),
        .o_bit_count(bit_count)
    );

    // Bit 0 select, bit 1 CAN wake, bit 2 LIN wake
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic [2:0] prev_r;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= 3'h1;
            sync_r <= 3'h1;
            prev_r <= 3'h1;
        end else begin
            meta_r <= {i_lin_wake, i_can_wake, i_serial_select_n};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic cs_rise;
    logic bus_wake_ev;
    logic frame_ok;
    logic setup_wr;
    logic wake_wr;
    logic par_ok;
    logic serve;

    // Frame words are only read two edges after select rose, when the serial clock is idle
    assign cs_rise = sync_r[0] & ~prev_r[0];
    assign bus_wake_ev = (sync_r[1] & ~prev_r[1]) | (sync_r[2] & ~prev_r[2]);
    assign frame_ok = cs_rise && (bit_count == FRAME_LEN) && frame.wr;
    assign setup_wr = frame_ok && (frame.addr == ADDR_SETUP);
    assign wake_wr = frame_ok && (frame.addr == ADDR_WAKE);
    assign par_ok = ~(^frame.data);
    assign serve = setup_wr && par_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Timing

    sbw_state_e state_r;
    sbw_state_e state_nxt;
    logic [TMR_W-1:0] timer_r;
    logic [TMR_W-1:0] timer_nxt;
    sbw_cfg_s cfg_r;
    sbw_cfg_s cfg_nxt;
    logic [TMR_W-1:0] long_cyc;
    logic [TMR_W-1:0] hold_cyc;
    logic [TMR_W-1:0] period_cyc;
    logic [TMR_W-1:0] closed_cyc;
    logic [TMR_W-1:0] limit;
    logic expired;
    logic closed;
    logic [1:0] fail_sat;

    assign long_cyc = ms_to_cyc(LONG_WIN_MS, CYC_PER_MS);
    assign hold_cyc = ms_to_cyc(RST_HOLD_MS, CYC_PER_MS);
    assign period_cyc = ms_to_cyc(period_ms(cfg_r.period), CYC_PER_MS);
    assign closed_cyc = ms_to_cyc(period_ms(cfg_r.period) * CLOSED_PCT / PCT_FULL,
                                  CYC_PER_MS);
    assign limit = (state_r == ST_LONG) ? long_cyc :
                   (state_r == ST_HOLD) ? hold_cyc : period_cyc;
    assign expired = (timer_r >= limit - 24'h00_0001);
    // Time-out mode has no closed part at all
    assign closed = (state_r == ST_RUN) && cfg_r.win && (timer_r < closed_cyc);
    assign fail_sat = (i_fail_config == FAIL_CFG_TWO) ? FAIL_SAT_CFG2 : FAIL_SAT_OTHER;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog control

    logic [1:0] fcnt_r;
    logic [1:0] fcnt_nxt;
    logic arm_r;
    logic arm_nxt;
    logic confirm_r;
    logic confirm_nxt;
    logic watchdog_failure_count_r;
    logic watchdog_failure_count_nxt;
    logic reset_n_r;
    logic reset_n_nxt;
    logic rxd_low_r;
    logic rxd_low_nxt;
    logic [5:0] pulse_r;
    logic [5:0] pulse_nxt;
    logic fail;
    logic normal;

    assign normal = (i_chip_mode == CM_NORMAL);

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r + 24'h00_0001;
        cfg_nxt = cfg_r;
        fcnt_nxt = fcnt_r;
        arm_nxt = arm_r;
        confirm_nxt = confirm_r;
        watchdog_failure_count_nxt = watchdog_failure_count_r;
        reset_n_nxt = reset_n_r;
        rxd_low_nxt = rxd_low_r;
        // Pulses: 0 restart, 1 failsafe, 2 normal, 3 irq, 4 serial fail
        pulse_nxt = 6'h00;
        fail = 1'b0;
        if (cs_rise && (bit_count != FRAME_LEN || (setup_wr && !par_ok))) begin
            pulse_nxt[4] = 1'b1;
        end
        // Disable sequence and bus-wake enable only move in Normal, but leaving the off state clears the sequence
        if (normal && wake_wr && frame.data[DAT_ARM]) begin
            arm_nxt = ~arm_r;
        end
        if (normal && serve) begin
            cfg_nxt.win = frame.data[DAT_TYPE];
            cfg_nxt.period = frame.data[DAT_PER_HI:DAT_PER_LO];
            cfg_nxt.bus_wake = frame.data[DAT_BUSWAKE];
            if (frame.data[DAT_CONFIRM]) begin
                confirm_nxt = arm_r;
            end
        end
        case (state_r)
            ST_HOLD: begin
                reset_n_nxt = 1'b0;
                if (expired) begin
                    reset_n_nxt = 1'b1;
                    state_nxt = ST_LONG;
                    timer_nxt = '0;
                    pulse_nxt[2] = watchdog_failure_count_r;
                end
            end
            ST_LONG, ST_RUN: begin
                if (serve && closed) begin
                    fail = 1'b1;
                end else if (serve) begin
                    state_nxt = ST_RUN;
                    timer_nxt = '0;
                    fcnt_nxt = 2'h0;
                    rxd_low_nxt = 1'b0;
                end else if (expired) begin
                    fail = 1'b1;
                end else if (i_chip_mode == CM_STOP && arm_r && confirm_r) begin
                    state_nxt = ST_OFF;
                    fcnt_nxt = 2'h0;
                end
            end
            ST_OFF: begin
                timer_nxt = '0;
                if (normal || i_chip_mode == CM_INIT || (i_chip_mode == CM_STOP && serve)) begin
                    state_nxt = ST_LONG;
                    arm_nxt = 1'b0;
                    confirm_nxt = 1'b0;
                end else if (i_chip_mode == CM_STOP && cfg_r.bus_wake && bus_wake_ev) begin
                    state_nxt = ST_LONG;
                    pulse_nxt[3] = 1'b1;
                    rxd_low_nxt = 1'b1;
                    // Stale bits would switch it off again at once; a new sequence is needed
                    arm_nxt = 1'b0;
                    confirm_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
                timer_nxt = '0;
            end
        endcase
        if (fail) begin
            if (fcnt_r < fail_sat) begin
                fcnt_nxt = fcnt_r + 2'h1;
            end
            state_nxt = ST_HOLD;
            timer_nxt = '0;
            reset_n_nxt = 1'b0;
            watchdog_failure_count_nxt = 1'b1;
            pulse_nxt[0] = ~i_fail_safe_select;
            pulse_nxt[1] = i_fail_safe_select;
        end
        // Marker must survive into the hold so the Normal request can follow
        if (normal && state_r != ST_HOLD && !fail) begin
            watchdog_failure_count_nxt = 1'b0;
        end
        // Off states override the state chosen above; Restart and Failsafe only outside the hold with the marker clear
        if (i_chip_mode == CM_SLEEP) begin
            state_nxt = ST_OFF;
            fcnt_nxt = 2'h0;
            reset_n_nxt = 1'b1;
        end else if ((i_chip_mode == CM_RESTART || i_chip_mode == CM_FAILSAFE)
                     && !watchdog_failure_count_r && state_r != ST_HOLD) begin
            state_nxt = ST_OFF;
            if (i_chip_mode == CM_FAILSAFE) begin
                fcnt_nxt = 2'h0;
            end
        end
        if (i_dev_mode) begin
            state_nxt = ST_OFF;
            fcnt_nxt = 2'h0;
            reset_n_nxt = 1'b1;
            pulse_nxt[1:0] = 2'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= ST_HOLD;
            timer_r <= '0;
            cfg_r <= CFG_RST;
            fcnt_r <= 2'h0;
            arm_r <= 1'b0;
            confirm_r <= 1'b0;
            watchdog_failure_count_r <= 1'b0;
            reset_n_r <= 1'b0;
            rxd_low_r <= 1'b0;
            pulse_r <= 6'h00;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            cfg_r <= cfg_nxt;
            fcnt_r <= fcnt_nxt;
            arm_r <= arm_nxt;
            confirm_r <= confirm_nxt;
            watchdog_failure_count_r <= watchdog_failure_count_nxt;
            reset_n_r <= reset_n_nxt;
            rxd_low_r <= rxd_low_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign o_reset_out_n = reset_n_r;
    assign o_enter_restart = pulse_r[0];
    assign o_enter_failsafe = pulse_r[1];
    assign o_enter_normal = pulse_r[2];
    assign o_wake_irq = pulse_r[3];
    assign o_spi_fail = pulse_r[4];
    assign o_rxd_pull_low = rxd_low_r;
    assign o_cfg = cfg_r;
    assign o_watchdog_failure_count = fcnt_r;
    assign o_stop_disable_arm_bit = arm_r;
    assign o_stop_disable_confirm_bit = confirm_r;
    assign o_wd_active = (state_r == ST_LONG) || (state_r == ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    logic quiet;
    assign quiet = normal && !i_dev_mode;

    sequence seq_hold_done;
        state_r == ST_HOLD && expired && quiet;
    endsequence

    sequence seq_long_released;
        state_r == ST_LONG && o_reset_out_n && timer_r == '0;
    endsequence

    AST_PARITY_IGNORE: assert property (
        (setup_wr && !par_ok) |=> (o_spi_fail && $stable(cfg_r)))
        else $error("bad parity write was not ignored");

    AST_RSVD_PARITY: assert property (
        (setup_wr && frame.data[DAT_RSVD] && ^frame.data[DAT_CHK:DAT_PER_LO]) |=> o_spi_fail)
        else $error("reserved bit not counted in parity");

    AST_CFG_FIXED: assert property (
        !normal |=> $stable(cfg_r))
        else $error("configuration changed outside normal mode");

    AST_TIMEOUT_EXPIRE: assert property (
        (state_r == ST_RUN && !cfg_r.win && expired && !serve && quiet)
        |=> (!o_reset_out_n && state_r == ST_HOLD))
        else $error("time-out expiry did not pull reset low");

    AST_CLOSED_FAIL: assert property (
        (serve && closed && quiet)
        |=> (!o_reset_out_n && (o_enter_restart || o_enter_failsafe)))
        else $error("closed window service not treated as failure");

    AST_SERVE_RESTART: assert property (
        (serve && !closed && quiet && (state_r == ST_RUN || state_r == ST_LONG))
        |=> (state_r == ST_RUN && timer_r == '0 && fcnt_r == 2'h0))
        else $error("accepted service did not restart period");

    AST_FAIL_SAT: assert property (
        $rose(watchdog_failure_count_r) |-> (fcnt_r <= fail_sat))
        else $error("failure counter passed its saturation value");

    AST_FAIL_INC: assert property (
        (fail && fcnt_r < fail_sat && !i_dev_mode && i_chip_mode != CM_SLEEP
         && !(i_chip_mode == CM_FAILSAFE && !watchdog_failure_count_r))
        |=> (fcnt_r == $past(fcnt_r) + 2'h1))
        else $error("failure did not increment counter");

    AST_HOLD_RELEASE: assert property (
        seq_hold_done |=> seq_long_released)
        else $error("reset release did not open long window");

    AST_DEV_OFF: assert property (
        i_dev_mode |=> (state_r == ST_OFF && o_reset_out_n))
        else $error("watchdog active in development mode");

    AST_ARM_TOGGLE: assert property (
        (normal && wake_wr && frame.data[DAT_ARM] && arm_r) |=> !arm_r)
        else $error("arm bit did not clear on repeated arm");

    AST_SEQ_ERR: assert property (
        (normal && serve && frame.data[DAT_CONFIRM] && !arm_r) |=> !confirm_r)
        else $error("confirm without arm was accepted");

    AST_BUS_WAKE: assert property (
        (state_r == ST_OFF && i_chip_mode == CM_STOP && cfg_r.bus_wake && bus_wake_ev
         && !serve && !i_dev_mode)
        |=> (o_wake_irq && o_rxd_pull_low && state_r == ST_LONG))
        else $error("bus wake did not restart watchdog");

endmodule // sbw_watchdog

// file: sim/sbw_host_model.sv
// Host-side serial master that serves the watchdog
`timescale 1ns/1ps
module sbw_host_model (
    // Serial link
    output logic o_serial_clk,
    output logic o_serial_select_n,
    output logic o_serial_data_in
);
    initial begin
        o_serial_clk = 1'b0;
        o_serial_select_n = 1'b1;
        o_serial_data_in = 1'b0;
    end
    // Clock only runs inside a frame; MSB first, change on falling edge
    task automatic send(input logic [15:0] w, input int n);
        int i;
        o_serial_select_n = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            o_serial_data_in = w[i % 16];
            #24 o_serial_clk = 1'b1;
            #24 o_serial_clk = 1'b0;
        end
        #24 o_serial_select_n = 1'b1;
        // Released line must not keep showing the last bit
        o_serial_data_in = ~o_serial_data_in;
        #500;
    endtask
endmodule // sbw_host_model

// file: sim/tb_top.sv
// Self-checking bench for the window / time-out watchdog
`timescale 1ns/1ps
module tb_top;
    import sbw_pkg::*;
    localparam int CPM = 10;
    localparam int LONG_CYC = LONG_WIN_MS * CPM;
    localparam sbw_cfg_s CFG_WIN = '{win: 1'b1, period: 3'h1, bus_wake: 1'b0};
    localparam sbw_cfg_s CFG_STP = '{win: 1'b0, period: 3'h1, bus_wake: 1'b1};
    logic i_clk;
    logic i_sys_rst;
    logic ser_clk;
    logic ser_sel_n;
    logic ser_dat;
    logic fs_sel;
    logic dev_mode;
    logic [2:0] fail_cfg;
    logic rst_n, go_rst, go_fs, go_norm, spi_fail, active;
    logic [1:0] fcnt;
    sbw_cfg_s cfg;
    logic f_rst, f_fs, f_norm, f_spi;
    logic irq, rxd_low, arm_bit, cfm_bit, can_wk, lin_wk, f_irq;
    sbw_chip_mode_e mode;
    int error_cnt = 0;
    int num_checks = 0;
    ////////////////////////////////////////////////////////////
    sbw_host_model host (.o_serial_clk(ser_clk), .o_serial_select_n(ser_sel_n),
        .o_serial_data_in(ser_dat));
    sbw_watchdog #(.CYC_PER_MS(CPM), .RST_HOLD_MS(1)) dut (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_serial_clk(ser_clk), .i_serial_select_n(ser_sel_n),
        .i_serial_data_in(ser_dat), .i_chip_mode(mode), .i_dev_mode(dev_mode),
        .i_fail_safe_select(fs_sel), .i_fail_config(fail_cfg), .i_can_wake(can_wk),
        .i_lin_wake(lin_wk), .o_reset_out_n(rst_n), .o_enter_restart(go_rst),
        .o_enter_failsafe(go_fs), .o_enter_normal(go_norm), .o_wake_irq(irq),
        .o_rxd_pull_low(rxd_low), .o_spi_fail(spi_fail), .o_cfg(cfg),
        .o_watchdog_failure_count(fcnt), .o_stop_disable_arm_bit(arm_bit),
        .o_stop_disable_confirm_bit(cfm_bit), .o_wd_active(active));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // Pulses are one cycle wide, so latch them for later judging
    always @(posedge i_clk) begin
        if (go_rst) f_rst <= 1'b1;
        if (go_fs) f_fs <= 1'b1;
        if (go_norm) f_norm <= 1'b1;
        if (spi_fail) f_spi <= 1'b1;
        if (irq) f_irq <= 1'b1;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic clr();
        f_rst = 1'b0;
        f_fs = 1'b0;
        f_norm = 1'b0;
        f_spi = 1'b0;
        f_irq = 1'b0;
    endtask
    task automatic wait_rst(input logic lvl, input int lim);
        int k;
        k = 0;
        while (rst_n !== lvl) begin
            cyc(1);
            k++;
            if (k > lim) begin
                check("reset_wait", 8'h00, 8'h01);
                print_verdict();
            end
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.send({d, 1'b1, a}, 16);
        cyc(6);
    endtask
    task automatic serve(input logic [7:0] d);
        wr(ADDR_SETUP, d);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("cfg", 8'(cfg), 8'(CFG_RST));
        check("fail_cnt", 8'(fcnt), 8'h00);
        i_sys_rst = 1'b0;
        cyc(5);
        check("reset_out_n", 8'(rst_n), 8'h00);
        wait_rst(1'b1, 40);
        cyc(1);
        check("wd_active", 8'(active), 8'h01);
    endtask
    task automatic t_window();
        clr();
        serve(8'h29); // Check bit 7 clear, so the checksum is off
        check("spi_fail", 8'(f_spi), 8'h01);
        check("cfg", 8'(cfg), 8'(CFG_RST));
        clr();
        serve(8'hA9);
        check("spi_fail", 8'(f_spi), 8'h00);
        check("cfg", 8'(cfg), 8'(CFG_WIN));
        serve(8'hA9); // Lands in the closed part
        wait_rst(1'b0, 40);
        cyc(2);
        check("enter_restart", 8'(f_rst), 8'h01);
        check("fail_cnt", 8'(fcnt), 8'h01);
        wait_rst(1'b1, 40);
        cyc(2);
        check("enter_normal", 8'(f_norm), 8'h01);
        serve(8'hA9);
        check("fail_cnt", 8'(fcnt), 8'h00);
        fs_sel = 1'b1;
        clr();
        cyc(61); // Service near 0.8 of the period
        serve(8'hA9);
        check("enter_restart", 8'(f_rst), 8'h00);
        wait_rst(1'b0, 140);
        cyc(2);
        check("enter_failsafe", 8'(f_fs), 8'h01);
    endtask
    task automatic t_sat();
        logic [2:0] cf [3] = '{3'h2, 3'h3, 3'h4};
        logic [1:0] ex [3] = '{2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 3; i++) begin
            fail_cfg = cf[i];
            wait_rst(1'b1, 40);
            wait_rst(1'b0, LONG_CYC + 40);
            cyc(2);
            check("fail_cnt", 8'(fcnt), 8'(ex[i]));
        end
    endtask
    task automatic t_timeout();
        wait_rst(1'b1, 40);
        serve(8'h81);
        clr();
        // Early services would hit a closed window in window mode
        repeat (4) begin
            cyc(30);
            serve(8'h81);
        end
        check("failure", 8'(f_fs | f_rst), 8'h00);
        check("fail_cnt", 8'(fcnt), 8'h00);
        wait_rst(1'b0, 140);
        cyc(2);
        check("enter_failsafe", 8'(f_fs), 8'h01);
    endtask
    task automatic t_stop();
        wait_rst(1'b1, 40);
        wr(ADDR_WAKE, 8'h01);
        wr(ADDR_WAKE, 8'h01);
        check("arm", 8'(arm_bit), 8'h00);
        serve(8'hD1); // Confirm with no arm before it
        check("confirm", 8'(cfm_bit), 8'h00);
        wr(ADDR_WAKE, 8'h01);
        serve(8'hD1);
        check("confirm", 8'(cfm_bit), 8'h01);
        check("cfg", 8'(cfg), 8'(CFG_STP));
        mode = CM_STOP;
        cyc(150);
        check("wd_active", 8'(active), 8'h00);
        check("reset_out_n", 8'(rst_n), 8'h01);
        clr();
        can_wk = 1'b1;
        cyc(6);
        check("wake_irq", 8'(f_irq), 8'h01);
        check("rxd_pull_low", 8'(rxd_low), 8'h01);
        check("wd_active", 8'(active), 8'h01);
        serve(8'hA9); // Stop mode must keep the setup
        check("cfg", 8'(cfg), 8'(CFG_STP));
        check("rxd_pull_low", 8'(rxd_low), 8'h00);
        mode = CM_NORMAL;
        wr(ADDR_WAKE, 8'h01);
        serve(8'hD1);
        mode = CM_STOP;
        cyc(3);
        check("wd_active", 8'(active), 8'h00);
        serve(8'hD1);
        check("wd_active", 8'(active), 8'h01);
        check("arm", 8'(arm_bit), 8'h00);
        check("confirm", 8'(cfm_bit), 8'h00);
        mode = CM_NORMAL;
        cyc(2);
    endtask
    task automatic t_dev();
        dev_mode = 1'b1;
        wait_rst(1'b1, 40);
        clr();
        cyc(LONG_CYC + 200);
        check("reset_out_n", 8'(rst_n), 8'h01);
        check("enter_failsafe", 8'(f_fs), 8'h00);
    endtask
    initial begin
        i_sys_rst = 1'b1;
        fs_sel = 1'b0;
        dev_mode = 1'b0;
        fail_cfg = 3'h2;
        mode = CM_NORMAL;
        can_wk = 1'b0;
        lin_wk = 1'b0;
        clr();
        cyc(16);
        t_reset();
        t_window();
        t_sat();
        t_timeout();
        t_stop();
        t_dev();
        print_verdict();
    end
endmodule // tb_top
